/* doti_link_model.sv */
// far-side link model making the two gear clock phases
// assumes a core clock eight times the link rate
`timescale 1ns/1ps
`default_nettype none

module doti_link_model (
	// clock and gate
	input wire logic clk_i,
	input wire logic run_i,
	// gear phases toward the block
	output logic ph0_o,
	output logic ph1_o
);
	logic [2:0] cnt;

	// phase 1 lags phase 0 a quarter period, both still when idle
	always_ff @(posedge clk_i) begin
		if (!run_i) begin
			cnt <= 3'h0;
			ph0_o <= 1'b0;
			ph1_o <= 1'b0;
		end else begin
			cnt <= cnt + 3'h1;
			ph0_o <= (cnt < 3'h4);
			ph1_o <= (cnt >= 3'h2) && (cnt < 3'h6);
		end
	end
endmodule

`default_nettype wire

/* doti_pkg.sv */
// constants, field layouts and carrier types of the ddr output path
// assumes a 32-bit axi4-lite register bus and a 12-lane strobe group
//
// Summary of operation
// RULE1: tri-state path has one sdr register plus an extra x2 gearing register.
// RULE2: in sdr and plain ddr, one flop on tristate_in drives enable.
// RULE3: in x2 gearing, a second register on both phases drives enable.
// RULE4: isi correction works only in x2 gearing, bypassed otherwise.
// RULE5: every lane holds its own isi setting, all twelve independent.
// RULE6: long runs of equal bits get no extension at all.
// RULE7: history 010 stretches the isolated one on the output.
// RULE8: history 101 stretches the isolated zero on the output.
// RULE9: a 3-bit control value selects the amount of stretch.
// RULE10: each strobe group applies its own 8-bit, 128-step output delay.
// RULE11: delay field msb inverts the incoming clock, a 180 degree shift.
// RULE12: output registers convert core words to line-rate bits.
// RULE13: low seven delay bits are an unsigned step, more is longer.
// RULE14: stretch grows with the 3-bit value, zero gives none.

`default_nettype none

package doti_pkg;

	// ==========================================================
	// geometry
	localparam int DOTI_LANES = 12;
	localparam int DOTI_SLOTS = 4;
	localparam int DOTI_WL_STEPS = 128;
	localparam int DOTI_WL_IDX_W = 7;
	localparam int DOTI_WL_W = 8;
	localparam int DOTI_ISI_W = 3;
	localparam int DOTI_ISI_PER_WORD = 8;

	// ==========================================================
	// register map, byte addresses
	localparam logic [7:0] DOTI_OFS_CTRL = 8'h00;
	localparam logic [7:0] DOTI_OFS_WLEVEL = 8'h04;
	localparam logic [7:0] DOTI_OFS_ISI_LO = 8'h08;
	localparam logic [7:0] DOTI_OFS_ISI_HI = 8'h0C;
	localparam logic [7:0] DOTI_OFS_STATUS = 8'h10;

	// ==========================================================
	// field positions and reset values
	localparam int DOTI_WL_INV_BIT = 7;
	localparam logic [7:0] DOTI_WL_RST = 8'h00;
	localparam logic [2:0] DOTI_ISI_RST = 3'h0;
	localparam logic [1:0] DOTI_RESP_OKAY = 2'h0;
	localparam logic [1:0] DOTI_RESP_SLVERR = 2'h2;

	// ==========================================================
	// isi history codes, older bit in the msb
	localparam logic [1:0] DOTI_HIST_ONE = 2'h1;
	localparam logic [1:0] DOTI_HIST_ZERO = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		DOTI_MODE_SDR,
		DOTI_MODE_DDR,
		DOTI_MODE_X2
	} doti_mode_t;

	typedef struct packed {
		logic strobe;
		logic [DOTI_LANES-1:0] oe;
		logic [DOTI_LANES-1:0] dq;
	} doti_pin_t;

	localparam doti_pin_t DOTI_PIN_RST = '{
		strobe: 1'b0,
		oe: '0,
		dq: '0
	};

endpackage

`default_nettype wire

/* doti_top.sv */
// ddr output and tri-state path of one strobe group with isi stretch
// assumes gear phases arrive as slow pins sampled by CORE_CLK_I
`timescale 1ns/1ps
`default_nettype none

module doti_top
	import doti_pkg::*;
#(
	parameter int WL_STEPS = DOTI_WL_STEPS
) (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// axi4-lite write address and data
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	// axi4-lite write response
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	// axi4-lite read
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// core side
	input wire logic TRISTATE_IN_I,
	input wire logic [DOTI_LANES*DOTI_SLOTS-1:0] TX_WORD_I,
	// gear clock phases from the link
	input wire logic GEAR_CLOCK_PHASE0_I,
	input wire logic GEAR_CLOCK_PHASE1_I,
	// pins
	output logic [DOTI_LANES-1:0] DQ_O,
	output logic [DOTI_LANES-1:0] DQ_OE_O,
	output logic STROBE_O
);

	// ==========================================================
	// reset release
	logic [1:0] rst_n_sync;
	logic rst_n;

	// two-flop release of the asynchronous reset
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_n_sync <= 2'h0;
		end else begin
			rst_n_sync <= {rst_n_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_n_sync[1];

	// ==========================================================
	// gear phase sampling
	logic p0_m, p0_s, p0_d;
	logic p1_m, p1_s, p1_d;
	logic p0_rise, p0_fall, p1_rise, p1_fall;

	// two flops per phase, third flop for edge finding
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			p0_m <= 1'b0;
			p0_s <= 1'b0;
			p0_d <= 1'b0;
			p1_m <= 1'b0;
			p1_s <= 1'b0;
			p1_d <= 1'b0;
		end else begin
			p0_m <= GEAR_CLOCK_PHASE0_I;
			p0_s <= p0_m;
			p0_d <= p0_s;
			p1_m <= GEAR_CLOCK_PHASE1_I;
			p1_s <= p1_m;
			p1_d <= p1_s;
		end
	end

	// edge strobes, one core cycle each
	assign p0_rise = p0_s & ~p0_d;
	assign p0_fall = ~p0_s & p0_d;
	assign p1_rise = p1_s & ~p1_d;
	assign p1_fall = ~p1_s & p1_d;

	// ==========================================================
	// register file state
	doti_mode_t mode, next_mode;
	logic [DOTI_WL_W-1:0] wl_step, next_wl_step;
	logic [DOTI_ISI_W-1:0] isi_set [DOTI_LANES];
	logic [DOTI_ISI_W-1:0] next_isi_set [DOTI_LANES];
	logic aw_got, next_aw_got, w_got, next_w_got;
	logic [7:0] waddr, next_waddr;
	logic [31:0] wdata, next_wdata;
	logic [3:0] wstrb, next_wstrb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [31:0] status_word;

	// byte-lane merge for partial writes
	function automatic logic [31:0] doti_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// current value of a register as software sees it
	function automatic logic [31:0] doti_read(input logic [7:0] addr,
		input doti_mode_t md, input logic [DOTI_WL_W-1:0] wl,
		input logic [DOTI_LANES*DOTI_ISI_W-1:0] isi,
		input logic [31:0] st, output logic hit);
		logic [31:0] res;
		res = 32'h0000_0000;
		hit = 1'b1;
		unique case ({addr[7:2], 2'h0})
			DOTI_OFS_CTRL: res[1:0] = md;
			DOTI_OFS_WLEVEL: res[DOTI_WL_W-1:0] = wl;
			DOTI_OFS_ISI_LO: res[23:0] = isi[23:0];
			DOTI_OFS_ISI_HI: res[11:0] = isi[35:24];
			DOTI_OFS_STATUS: res = st;
			default: hit = 1'b0;
		endcase
		return res;
	endfunction

	logic [DOTI_LANES*DOTI_ISI_W-1:0] isi_flat;
	logic tri_sdr, tri_gear, oe_now;

	// per-lane settings flattened for reading
	always_comb begin
		for (int l = 0; l < DOTI_LANES; l++) begin
			isi_flat[l*DOTI_ISI_W +: DOTI_ISI_W] = isi_set[l];
		end
	end

	// live state shown to software
	assign status_word = {27'h000_0000, p1_s, p0_s, tri_gear, tri_sdr,
		oe_now};

	assign S_AXI_AWREADY_O = ~aw_got & ~bvalid;
	assign S_AXI_WREADY_O = ~w_got & ~bvalid;
	assign S_AXI_ARREADY_O = ~rvalid;
	assign S_AXI_BVALID_O = bvalid;
	assign S_AXI_BRESP_O = bresp;
	assign S_AXI_RVALID_O = rvalid;
	assign S_AXI_RDATA_O = rdata;
	assign S_AXI_RRESP_O = rresp;

	// bus slave: address and data in either order, then one response
	always_comb begin
		logic [31:0] cur;
		logic [31:0] mrg;
		logic hit;
		logic rhit;
		cur = 32'h0000_0000;
		mrg = 32'h0000_0000;
		hit = 1'b0;
		rhit = 1'b0;
		next_mode = mode;
		next_wl_step = wl_step;
		next_isi_set = isi_set;
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_waddr = waddr;
		next_wdata = wdata;
		next_wstrb = wstrb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
			next_aw_got = 1'b1;
			next_waddr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
			next_w_got = 1'b1;
			next_wdata = S_AXI_WDATA_I;
			next_wstrb = S_AXI_WSTRB_I;
		end
		if (aw_got && w_got && !bvalid) begin
			cur = doti_read(waddr, mode, wl_step, isi_flat, status_word,
				hit);
			mrg = doti_merge(cur, wdata, wstrb);
			unique case ({waddr[7:2], 2'h0})
				DOTI_OFS_CTRL: next_mode = doti_mode_t'(mrg[1:0]);
				DOTI_OFS_WLEVEL: next_wl_step = mrg[DOTI_WL_W-1:0];
				DOTI_OFS_ISI_LO: begin
					for (int l = 0; l < DOTI_ISI_PER_WORD; l++) begin
						next_isi_set[l] = mrg[l*DOTI_ISI_W +: DOTI_ISI_W]; // RULE5
					end
				end
				DOTI_OFS_ISI_HI: begin
					for (int l = DOTI_ISI_PER_WORD; l < DOTI_LANES; l++) begin
						next_isi_set[l] =
							mrg[(l-DOTI_ISI_PER_WORD)*DOTI_ISI_W +: DOTI_ISI_W];
					end
				end
				default: hit = 1'b0;
			endcase
			if ({waddr[7:2], 2'h0} == DOTI_OFS_STATUS) begin
				hit = 1'b0;
			end
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = hit ? DOTI_RESP_OKAY : DOTI_RESP_SLVERR;
		end else if (bvalid && S_AXI_BREADY_I) begin
			next_bvalid = 1'b0;
		end
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			next_rdata = doti_read(S_AXI_ARADDR_I, mode, wl_step, isi_flat,
				status_word, rhit);
			next_rresp = rhit ? DOTI_RESP_OKAY : DOTI_RESP_SLVERR;
			next_rvalid = 1'b1;
		end else if (rvalid && S_AXI_RREADY_I) begin
			next_rvalid = 1'b0;
		end
	end

	// register file flops
	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			mode <= DOTI_MODE_SDR;
			wl_step <= DOTI_WL_RST;
			for (int l = 0; l < DOTI_LANES; l++) begin
				isi_set[l] <= DOTI_ISI_RST;
			end
			aw_got <= 1'b0;
			w_got <= 1'b0;
			waddr <= 8'h00;
			wdata <= 32'h0000_0000;
			wstrb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= DOTI_RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= DOTI_RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			mode <= next_mode;
			wl_step <= next_wl_step;
			isi_set <= next_isi_set;
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			waddr <= next_waddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	// ==========================================================
	// gearing slots and tri-state registers
	logic slot_evt;
	logic [1:0] slot_idx;
	logic is_x2;
	logic [DOTI_LANES*DOTI_SLOTS-1:0] word_q, next_word_q;
	logic next_tri_sdr, next_tri_gear;

	assign is_x2 = (mode == DOTI_MODE_X2);

	// line slots per core word: one, two or four by mode
	always_comb begin
		slot_evt = 1'b0;
		slot_idx = 2'h0;
		unique case (mode)
			DOTI_MODE_DDR: begin
				slot_evt = p0_rise | p0_fall; // RULE12
				slot_idx = p0_fall ? 2'h1 : 2'h0;
			end
			DOTI_MODE_X2: begin
				slot_evt = p0_rise | p1_rise | p0_fall | p1_fall; // RULE12
				slot_idx = p1_fall ? 2'h3 : p0_fall ? 2'h2 :
					p1_rise ? 2'h1 : 2'h0;
			end
			default: slot_evt = p0_rise;
		endcase
	end

	// word capture and the two tri-state registers
	always_comb begin
		next_word_q = p0_rise ? TX_WORD_I : word_q;
		next_tri_sdr = p0_rise ? TRISTATE_IN_I : tri_sdr; // RULE1 RULE2
		next_tri_gear = tri_gear;
		if (is_x2 && (p0_rise | p0_fall | p1_rise | p1_fall)) begin
			next_tri_gear = tri_sdr; // RULE3
		end
		oe_now = is_x2 ? ~tri_gear : ~tri_sdr; // RULE2 RULE3
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
			tri_sdr <= 1'b1;
			tri_gear <= 1'b1;
		end else begin
			word_q <= next_word_q;
			tri_sdr <= next_tri_sdr;
			tri_gear <= next_tri_gear;
		end
	end

	// ==========================================================
	// per-lane serialiser with isi stretch
	logic [DOTI_LANES-1:0] lane_dq;

	for (genvar l = 0; l < DOTI_LANES; l++) begin : g_lane
		logic [1:0] hist, next_hist;
		logic line, next_line, held, next_held;
		logic [DOTI_ISI_W-1:0] cnt, next_cnt;
		logic [DOTI_SLOTS-1:0] src;
		logic new_bit, lone;

		// next line bit, history and stretch counter
		always_comb begin
			src = p0_rise ? TX_WORD_I[l*DOTI_SLOTS +: DOTI_SLOTS] :
				word_q[l*DOTI_SLOTS +: DOTI_SLOTS];
			new_bit = src[slot_idx];
			lone = (hist == DOTI_HIST_ONE && !new_bit) ||
				(hist == DOTI_HIST_ZERO && new_bit); // RULE7 RULE8
			next_hist = hist;
			next_line = line;
			next_held = held;
			next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
			if (slot_evt) begin
				next_hist = {hist[0], new_bit};
				next_line = new_bit;
				if (is_x2 && lone) begin // RULE4
					next_held = line; // RULE7 RULE8
					next_cnt = isi_set[l]; // RULE9 RULE14
				end else begin
					next_cnt = '0; // RULE6
				end
			end
		end

		always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
			if (!rst_n) begin
				hist <= 2'h0;
				line <= 1'b0;
				held <= 1'b0;
				cnt <= '0;
			end else begin
				hist <= next_hist;
				line <= next_line;
				held <= next_held;
				cnt <= next_cnt;
			end
		end

		// old bit shown while the stretch runs
		assign lane_dq[l] = (cnt != '0) ? held : line; // RULE14
	end

	// ==========================================================
	// write-leveling delay line
	doti_pin_t pipe [WL_STEPS];
	doti_pin_t next_pipe [WL_STEPS];
	doti_pin_t pin_now, pin_q, next_pin_q;
	logic [DOTI_WL_IDX_W-1:0] wl_idx;

	assign wl_idx = wl_step[DOTI_WL_IDX_W-1:0]; // RULE13

	// group output before delay, clock inverted on request
	always_comb begin
		pin_now.strobe = p0_s ^ wl_step[DOTI_WL_INV_BIT]; // RULE11
		pin_now.oe = {DOTI_LANES{oe_now}};
		pin_now.dq = lane_dq;
	end

	// one stage per step, tap chosen by the step index
	always_comb begin
		next_pipe[0] = pin_now;
		for (int i = 1; i < WL_STEPS; i++) begin
			next_pipe[i] = pipe[i-1];
		end
		next_pin_q = pipe[wl_idx]; // RULE10 RULE13
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < WL_STEPS; i++) begin
				pipe[i] <= DOTI_PIN_RST;
			end
			pin_q <= DOTI_PIN_RST;
		end else begin
			pipe <= next_pipe;
			pin_q <= next_pin_q;
		end
	end

	// pins straight from the output flops
	assign DQ_O = pin_q.dq;
	assign DQ_OE_O = pin_q.oe;
	assign STROBE_O = pin_q.strobe;

endmodule

`default_nettype wire

/* doti_top_sva.sv */
// checker of bus handshakes and lane enables of doti_top
// assumes binding into doti_top, seeing only its ports
`timescale 1ns/1ps
`default_nettype none

module doti_top_sva
	import doti_pkg::*;
#(
	parameter int WL_STEPS = DOTI_WL_STEPS
) (
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// bus handshakes
	input wire logic S_AXI_AWVALID_I,
	input wire logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input wire logic S_AXI_WREADY_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_ARVALID_I,
	input wire logic S_AXI_ARREADY_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// pins
	input wire logic [DOTI_LANES-1:0] DQ_OE_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);

	// ==========================================================
	// write channel
	a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O
		&& S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O)
		else $error("write response not two cycles after handshake");
	a_write_refuse: assert property (S_AXI_BVALID_O |->
		!S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write accepted while response pending");
	a_bvalid_cause: assert property ($rose(S_AXI_BVALID_O) |->
		!$past(S_AXI_AWREADY_O) && !$past(S_AXI_WREADY_O))
		else $error("write response without both channels taken");
	a_bvalid_clear: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
		|=> !S_AXI_BVALID_O)
		else $error("write response not released");

	// ==========================================================
	// read channel
	a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
		|=> S_AXI_RVALID_O)
		else $error("read data not one cycle after handshake");
	a_read_refuse: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
		else $error("read accepted while data pending");
	a_rvalid_cause: assert property (S_AXI_RVALID_O |->
		($past(S_AXI_ARVALID_I) && $past(S_AXI_ARREADY_O))
		|| ($past(S_AXI_RVALID_O) && !$past(S_AXI_RREADY_I)))
		else $error("read data without a request");

	// ==========================================================
	// lane enables share one tri-state register
	a_oe_shared: assert property (DQ_OE_O == '0 || DQ_OE_O == '1)
		else $error("lane enables disagree");
endmodule

bind doti_top doti_top_sva #(.WL_STEPS(WL_STEPS)) i_doti_top_sva (.*);

`default_nettype wire

/* test_doti_top.sv */
// self-checking bench of doti_top with register bus and link model
// assumes doti_pkg and doti_link_model compiled before
`timescale 1ns/1ps
`default_nettype none

module test_doti_top
	import doti_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, tri_in = 1'b1, run = 1'b0;
	logic [47:0] tx = 48'h0000_0000_0000;
	logic awready, wready, bvalid, arready, rvalid, strobe, ph0, ph1;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [11:0] dq, oe;
	doti_pin_t pins;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;

	assign pins = '{strobe: strobe, oe: oe, dq: dq};

	// ==========================================================
	// clock, device and link
	always #25 clk = ~clk;

	doti_top i_doti_top (.CORE_CLK_I(clk), .RST_N_I(rst_n),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .TRISTATE_IN_I(tri_in), .TX_WORD_I(tx),
		.GEAR_CLOCK_PHASE0_I(ph0), .GEAR_CLOCK_PHASE1_I(ph1),
		.DQ_O(dq), .DQ_OE_O(oe), .STROBE_O(strobe));

	doti_link_model i_doti_link_model (.clk_i(clk), .run_i(run),
		.ph0_o(ph0), .ph1_o(ph1));

	// ==========================================================
	// compare, bus and sampling tasks
	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input doti_pin_t got, input doti_pin_t exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// pins n core edges after a phase 0 rise, one period skipped
	task automatic at_edge(input int n, output doti_pin_t p);
		repeat (2) begin
			@(negedge clk iff ph0 === 1'b0);
			@(negedge clk iff ph0 === 1'b1);
		end
		repeat (n) @(posedge clk);
		@(negedge clk);
		p = pins;
	endtask

	task automatic cfg(input doti_mode_t m, input logic [7:0] w,
		input logic [47:0] x);
		logic [1:0] r;
		wr(DOTI_OFS_CTRL, {30'h0, m}, r);
		wr(DOTI_OFS_WLEVEL, {24'h00_0000, w}, r);
		wr(DOTI_OFS_ISI_LO, 32'h0000_048A, r);
		chk_bus({30'h0, r}, {30'h0, DOTI_RESP_OKAY});
		tx <= x;
		run <= 1'b1;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rd(DOTI_OFS_STATUS, d, r);
		chk_bus(d, 32'h0000_0006);
		rd(DOTI_OFS_WLEVEL, d, r);
		chk_bus(d, {24'h00_0000, DOTI_WL_RST});
		wr(DOTI_OFS_WLEVEL, 32'h0000_00FF, r);
		rd(DOTI_OFS_WLEVEL, d, r);
		chk_bus(d, 32'h0000_00FF);
		rd(8'h20, d, r);
		chk_bus({30'h0, r}, {30'h0, DOTI_RESP_SLVERR});
		wr(DOTI_OFS_STATUS, 32'h0000_0001, r);
		chk_bus({30'h0, r}, {30'h0, DOTI_RESP_SLVERR});
		wr(DOTI_OFS_ISI_HI, 32'hFFFF_FFFF, r);
		rd(DOTI_OFS_ISI_HI, d, r);
		chk_bus(d, 32'h0000_0FFF);
		wr(DOTI_OFS_CTRL, 32'h0000_0003, r);
		rd(DOTI_OFS_CTRL, d, r);
		chk_bus(d, 32'h0000_0003);
	endtask

	task automatic t_sdr();
		doti_pin_t p;
		cfg(DOTI_MODE_SDR, 8'h00, 48'h0000_0000_0001);
		tri_in <= 1'b0;
		at_edge(6, p);
		chk_pin(p, '{1'b1, 12'hFFF, 12'h001});
		@(posedge clk);
		tri_in <= 1'b1;
		at_edge(6, p);
		chk_pin(p, '{1'b1, 12'h000, 12'h001});
	endtask

	task automatic t_x2();
		doti_pin_t p;
		@(posedge clk);
		tri_in <= 1'b0;
		cfg(DOTI_MODE_X2, 8'h00, 48'h0000_0002_DC22);
		at_edge(6, p);
		chk_pin(p, '{1'b1, 12'hFFF, 12'h008});
		at_edge(9, p);
		chk_pin(p, '{1'b0, 12'hFFF, 12'h007});
		at_edge(10, p);
		chk_pin(p, '{1'b0, 12'hFFF, 12'h005});
		@(posedge clk);
		tri_in <= 1'b1;
		at_edge(6, p);
		chk_pin(p, '{1'b1, 12'h000, 12'h008});
		@(posedge clk);
		tri_in <= 1'b0;
	endtask

	task automatic t_ddr();
		doti_pin_t p;
		cfg(DOTI_MODE_DDR, 8'h00, 48'h0000_0000_0001);
		at_edge(6, p);
		chk_pin(p, '{1'b1, 12'hFFF, 12'h001});
		at_edge(10, p);
		chk_pin(p, '{1'b0, 12'hFFF, 12'h000});
	endtask

	task automatic t_wl();
		doti_pin_t p;
		cfg(DOTI_MODE_X2, 8'h03, 48'h0000_0002_DC22);
		at_edge(9, p);
		chk_pin(p, '{1'b1, 12'hFFF, 12'h008});
		cfg(DOTI_MODE_X2, 8'h83, 48'h0000_0002_DC22);
		at_edge(9, p);
		chk_pin(p, '{1'b0, 12'hFFF, 12'h008});
		run <= 1'b0;
	endtask

	// ==========================================================
	// verdict, timeout and main sequence
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_sdr();
		t_x2();
		t_ddr();
		t_wl();
		report_and_stop();
	end
endmodule

`default_nettype wire
